// File: lane_map_pkg.sv
// constants for the sample-to-lane mapper and serializer power control
// assumes a 32-bit axi4-lite register bus and one 20 MHz clock
package lane_map_pkg;
	localparam int LANES = 16;
	localparam int LANES_PER_LINK = 8;
	localparam int SAMPLES = 20;
	localparam int SAMPLE_W = 16;
	localparam int SAMPLE_VEC_W = SAMPLES * SAMPLE_W;
	localparam int FRAME_W = 64;
	localparam int ADDR_W = 8;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] POWER_STATE_OFS = 8'h04;
	localparam logic [7:0] TEST_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	// control field positions
	localparam int CFG_LSB = 0;
	localparam int BIND_A_BIT = 8;
	localparam int BIND_B_BIT = 9;
	localparam int PD_A_BIT = 12;
	localparam int PD_B_BIT = 13;
	localparam int EXTRA_A_BIT = 16;
	localparam int EXTRA_B_BIT = 17;
	localparam int LINK_EN_BIT = 24;
	localparam logic [31:0] CTRL_MASK = 32'h0103_331f;
	localparam logic [31:0] CTRL_RESET = 32'h0000_000a;
	localparam logic [7:0] POWER_STATE_RESET = 8'h00;
	localparam logic [7:0] POWER_STATE_MAX_ON = 8'h01;
	localparam logic [3:0] TEST_RESET = 4'h0;
	localparam int STATUS_PIN_BIT = 16;
	localparam int STATUS_ALL_OFF_BIT = 17;
	// link configurations
	localparam logic [4:0] CFG_10 = 5'd10;
	localparam logic [4:0] CFG_11 = 5'd11;
	localparam logic [4:0] CFG_12 = 5'd12;
	localparam logic [4:0] CFG_13 = 5'd13;
	localparam logic [4:0] CFG_14 = 5'd14;
	localparam logic [4:0] CFG_15 = 5'd15;
	localparam logic [4:0] CFG_16 = 5'd16;
	localparam logic [4:0] CFG_17 = 5'd17;
	localparam logic [4:0] CFG_18 = 5'd18;
	// test pattern codes
	localparam logic [3:0] TEST_OFF = 4'h0;
	localparam logic [3:0] TEST_RAMP = 4'h1;
	localparam logic [3:0] TEST_TOGGLE = 4'h2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : lane_map_pkg

// File: lane_mapping_power_control.sv
// transport-layer lane mapper with serializer power control and register slave
// assumes samples arrive one frame at a time on aclk, pin input is asynchronous
// Summary of operation
// - config 10: I on lane 0, Q on lane 1
// - config 11: lanes carry I0, I1, Q0, Q1
// - config 12: five 12-bit samples plus tail nibble
// - config 13: one lane, I then Q
// - config 14: same layout as config 10
// - config 15: lane A0 carries AI, AQ, BI, BQ
// - config 16: one lane per link, I then Q
// - config 17: lane Ak sample 2k, Bk 2k+1
// - config 18: lane Ak sample Ak, Bk Bk
// - binding routes one channel to both paths
// - redundant data except in single-channel config
// - unused channel may power down while bound
// - power-down pin disables all lane drivers
// - power state above one disables all lanes
// - channel power-down kills its lanes
// - fewer lanes: highest lanes powered down
// - keepalive keeps unused lanes on and toggling
// - test pattern chosen by select field
// - lane power follows configuration, not test
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module lane_mapping_power_control
	import lane_map_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [lane_map_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [lane_map_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pin
	input wire logic power_down_pin,
	// sample frame in
	input wire logic frame_valid,
	input wire logic [lane_map_pkg::SAMPLE_VEC_W-1:0] chan_a_inphase,
	input wire logic [lane_map_pkg::SAMPLE_VEC_W-1:0] chan_a_quadrature,
	input wire logic [lane_map_pkg::SAMPLE_VEC_W-1:0] chan_b_inphase,
	input wire logic [lane_map_pkg::SAMPLE_VEC_W-1:0] chan_b_quadrature,
	// lanes out
	output logic [lane_map_pkg::FRAME_W-1:0] lane_data [lane_map_pkg::LANES],
	output logic [lane_map_pkg::LANES-1:0] lane_enable,
	output logic frame_strobe
);
	import lane_map_pkg::*;

	////////////////////////////////////////////////////////////////
	// sample helpers

	function automatic logic [15:0] w16(input logic [SAMPLE_VEC_W-1:0] v, input int n);
		w16 = {v[SAMPLE_W*n +: 15], 1'b0};
	endfunction : w16

	function automatic logic [11:0] s12(input logic [SAMPLE_VEC_W-1:0] v, input int n);
		s12 = v[SAMPLE_W*n +: 12];
	endfunction : s12

	function automatic logic [7:0] s8(input logic [SAMPLE_VEC_W-1:0] v, input int n);
		s8 = v[SAMPLE_W*n +: 8];
	endfunction : s8

	// octet 0 sits in bits 63:56 and goes out first
	function automatic logic [FRAME_W-1:0] lane_map(input logic [4:0] cfg, input logic lnk, input logic [2:0] k,
			input logic [SAMPLE_VEC_W-1:0] ci, input logic [SAMPLE_VEC_W-1:0] cq,
			input logic [SAMPLE_VEC_W-1:0] oi, input logic [SAMPLE_VEC_W-1:0] oq);
		logic [FRAME_W-1:0] r;
		int p;
		r = '0;
		p = int'(k[2:1]);
		case (cfg)
			CFG_10, CFG_14: begin
				if (k == 3'd0) r = {w16(ci, 0), 48'h0};
				else if (k == 3'd1) r = {w16(cq, 0), 48'h0};
			end
			CFG_11: begin
				if (k < 3'd4) r = {w16(k[1] ? cq : ci, int'(k[0])), 48'h0};
			end
			CFG_12: begin
				r = {s12(k[0] ? cq : ci, p), s12(k[0] ? cq : ci, p + 4), s12(k[0] ? cq : ci, p + 8),
					s12(k[0] ? cq : ci, p + 12), s12(k[0] ? cq : ci, p + 16), 4'h0};
			end
			CFG_13, CFG_16: begin
				if (k == 3'd0) r = {w16(ci, 0), w16(cq, 0), 32'h0};
			end
			CFG_15: begin
				if (!lnk && k == 3'd0) r = {w16(ci, 0), w16(cq, 0), w16(oi, 0), w16(oq, 0)};
			end
			CFG_17: r = {s8(lnk ? oi : ci, 2 * int'(k) + int'(lnk)), 56'h0};
			CFG_18: r = {s8(ci, int'(k)), 56'h0};
			default: r = '0;
		endcase
		lane_map = r;
	endfunction : lane_map

	function automatic logic [3:0] lanes_used(input logic [4:0] cfg, input logic lnk);
		case (cfg)
			CFG_10, CFG_14: lanes_used = 4'd2;
			CFG_11: lanes_used = 4'd4;
			CFG_12, CFG_17, CFG_18: lanes_used = 4'd8;
			CFG_13, CFG_16: lanes_used = 4'd1;
			CFG_15: lanes_used = lnk ? 4'd0 : 4'd1;
			default: lanes_used = 4'd0;
		endcase
	endfunction : lanes_used

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			old[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
		end
		merge = old;
	endfunction : merge

	////////////////////////////////////////////////////////////////
	// registers and bus slave

	logic [31:0] ctrl;
	logic [7:0] power_state;
	logic [3:0] test_pattern_select;
	logic got_aw;
	logic got_w;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic pin_meta;
	logic pin_s2;
	logic pin_s3;
	logic pd_state;
	logic [7:0] ramp;

	wire [4:0] link_configuration_select = ctrl[CFG_LSB +: 5];
	wire channel_a_binding = ctrl[BIND_A_BIT];
	wire channel_b_binding = ctrl[BIND_B_BIT];
	wire channel_a_power_down = ctrl[PD_A_BIT];
	wire channel_b_power_down = ctrl[PD_B_BIT];
	wire link_a_extra_lane_keepalive = ctrl[EXTRA_A_BIT];
	wire link_b_extra_lane_keepalive = ctrl[EXTRA_B_BIT];
	wire link_enable = ctrl[LINK_EN_BIT];
	wire do_write = got_aw && got_w && !bvalid;
	wire wr_ctrl = wr_addr == CTRL_OFS;
	wire wr_pstate = wr_addr == POWER_STATE_OFS;
	wire wr_test = wr_addr == TEST_OFS && !link_enable;
	wire wr_hit = wr_addr == CTRL_OFS || wr_pstate || wr_addr == TEST_OFS;
	wire all_off = pd_state || power_state > POWER_STATE_MAX_ON;
	wire ar_hit = araddr == CTRL_OFS || araddr == POWER_STATE_OFS || araddr == TEST_OFS || araddr == STATUS_OFS;
	wire [31:0] status_word = {14'h0, all_off, pd_state, lane_enable};
	wire [31:0] rd_word = araddr == CTRL_OFS ? ctrl : araddr == POWER_STATE_OFS ? {24'h0, power_state} :
		araddr == TEST_OFS ? {28'h0, test_pattern_select} : araddr == STATUS_OFS ? status_word : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			got_aw <= 1'b0;
			got_w <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				got_aw <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				got_w <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (do_write) begin
				got_aw <= 1'b0;
				got_w <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RESET;
			power_state <= POWER_STATE_RESET;
			test_pattern_select <= TEST_RESET;
		end else if (do_write) begin
			if (wr_ctrl) ctrl <= merge(ctrl, wr_data, wr_strb) & CTRL_MASK;
			if (wr_pstate && wr_strb[0]) power_state <= wr_data[7:0];
			if (wr_test && wr_strb[0]) test_pattern_select <= wr_data[3:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= ar_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// power-down pin synchroniser

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
			pd_state <= 1'b0;
		end else begin
			pin_meta <= power_down_pin;
			pin_s2 <= pin_meta;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3) pd_state <= pin_s3;
		end
	end

	////////////////////////////////////////////////////////////////
	// channel binding and lane power

	wire dual = link_configuration_select != CFG_17;
	wire bind_a = channel_a_binding && dual;
	wire bind_b = channel_b_binding && dual && !channel_a_binding;
	wire [SAMPLE_VEC_W-1:0] link_a_i = bind_b ? chan_b_inphase : chan_a_inphase;
	wire [SAMPLE_VEC_W-1:0] link_a_q = bind_b ? chan_b_quadrature : chan_a_quadrature;
	wire [SAMPLE_VEC_W-1:0] link_b_i = bind_a ? chan_a_inphase : chan_b_inphase;
	wire [SAMPLE_VEC_W-1:0] link_b_q = bind_a ? chan_a_quadrature : chan_b_quadrature;
	// a powered-down channel keeps its lanes only when the other channel is bound onto them
	wire off_a = channel_a_power_down && !bind_b;
	wire off_b = channel_b_power_down && !bind_a;
	wire take = frame_valid && link_enable && !all_off;

	logic [LANES-1:0] next_enable;
	logic [FRAME_W-1:0] next_data [LANES];

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : lane_g
			localparam logic LNK = 1'(g / LANES_PER_LINK);
			localparam logic [2:0] K = 3'(g % LANES_PER_LINK);
			wire used = {1'b0, K} < lanes_used(link_configuration_select, LNK);
			wire keep = LNK ? link_b_extra_lane_keepalive : link_a_extra_lane_keepalive;
			wire [FRAME_W-1:0] mapped = LNK ?
				lane_map(link_configuration_select, LNK, K, link_b_i, link_b_q, link_a_i, link_a_q) :
				lane_map(link_configuration_select, LNK, K, link_a_i, link_a_q, link_b_i, link_b_q);
			wire [FRAME_W-1:0] pattern = test_pattern_select == TEST_RAMP ? {8{ramp}} :
				test_pattern_select == TEST_TOGGLE ? {8{{8{ramp[0]}}}} : mapped;
			assign next_enable[g] = !all_off && !(LNK ? off_b : off_a) && (used || keep);
			assign next_data[g] = !next_enable[g] ? '0 : used ? pattern : {8{ramp}};
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// frame output register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lane_enable <= '0;
			frame_strobe <= 1'b0;
			ramp <= '0;
			for (int i = 0; i < LANES; i++) lane_data[i] <= '0;
		end else begin
			lane_enable <= next_enable;
			frame_strobe <= take;
			if (take) begin
				ramp <= ramp + 8'h01;
				for (int i = 0; i < LANES; i++) lane_data[i] <= next_data[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire plain = test_pattern_select == TEST_OFF;
	wire no_pd = !channel_a_power_down && !channel_b_power_down;
	wire two_lane = link_configuration_select == CFG_13 || link_configuration_select == CFG_16;

	pin_off_a: assert property (pd_state |=> lane_enable == '0)
		else $error("lanes on while pin power-down active");
	pin_sync_a: assert property ($rose(pin_s3) && pin_s2 |=> ##0 pd_state ##1 lane_enable == '0)
		else $error("pin power-down not applied");
	state_off_a: assert property (power_state > 8'h01 |=> lane_enable == '0 && !frame_strobe)
		else $error("lanes on with power state above one");
	lane_count_a: assert property (!all_off && link_configuration_select == CFG_11 && no_pd
		&& !link_a_extra_lane_keepalive |=> lane_enable[7:0] == 8'h0f)
		else $error("wrong lane count for four-lane link");
	keepalive_a: assert property (!all_off && link_configuration_select == CFG_13 && no_pd
		&& link_b_extra_lane_keepalive |=> lane_enable[15:8] == 8'hff)
		else $error("keepalive lanes not enabled");
	chan_pd_a: assert property (!all_off && channel_a_power_down && !bind_b |=> lane_enable[7:0] == 8'h00)
		else $error("powered-down channel lanes active");
	test_power_a: assert property (!all_off && no_pd && !ctrl[EXTRA_A_BIT] && !ctrl[EXTRA_B_BIT]
		&& link_configuration_select == CFG_10 |=> lane_enable == 16'h0303)
		else $error("lane power depends on more than configuration");
	cfg10_map_a: assert property (take && plain && link_configuration_select == CFG_10 && !bind_a && !bind_b
		&& !off_a |=> lane_data[1][63:48] == {$past(chan_a_quadrature[14:0]), 1'b0})
		else $error("config 10 quadrature misplaced");
	cfg15_map_a: assert property (take && plain && link_configuration_select == CFG_15 && !bind_a && !bind_b
		&& !off_a |=> lane_data[0][31:16] == {$past(chan_b_inphase[14:0]), 1'b0})
		else $error("config 15 octet order wrong");
	cfg17_map_a: assert property (take && plain && link_configuration_select == CFG_17 && !off_b
		|=> lane_data[9][63:56] == $past(chan_a_inphase[55:48]))
		else $error("config 17 interleave wrong");
	bind_map_a: assert property (take && plain && link_configuration_select == CFG_18 && channel_a_binding
		&& !off_a && !off_b |=> lane_data[8] == lane_data[0])
		else $error("bound channel not on both links");
	strobe_a: assert property (take |=> frame_strobe ##1 (frame_strobe == $past(take)))
		else $error("frame strobe misaligned");

	cfg11_map_a: assert property (take && plain && link_configuration_select == CFG_11 && !bind_a && !bind_b
		&& !off_a |=> lane_data[2][63:48] == {$past(chan_a_quadrature[14:0]), 1'b0})
		else $error("config 11 quadrature misplaced");
	cfg12_map_a: assert property (take && plain && link_configuration_select == CFG_12 && !bind_a && !bind_b
		&& !off_b |=> lane_data[11][63:52] == $past(chan_b_quadrature[27:16]) && lane_data[11][3:0] == 4'h0)
		else $error("config 12 sample packing wrong");
	cfg13_map_a: assert property (take && plain && two_lane && !bind_a && !bind_b && !off_b
		|=> lane_data[8][47:32] == {$past(chan_b_quadrature[14:0]), 1'b0})
		else $error("two-lane frame order wrong");
	lsb_zero_a: assert property (take && plain && link_configuration_select == CFG_10 && !off_a
		|=> !lane_data[0][48])
		else $error("low pad bit of sample not zero");
	ramp_data_a: assert property (take && test_pattern_select == TEST_RAMP && next_enable[0]
		|=> lane_data[0] == {8{$past(ramp)}})
		else $error("ramp pattern missing on lane");
	toggle_data_a: assert property (take && test_pattern_select == TEST_TOGGLE && next_enable[1]
		&& link_configuration_select == CFG_10 |=> lane_data[1] == {64{$past(ramp[0])}})
		else $error("toggle pattern missing on lane");
	keep_data_a: assert property (take && link_configuration_select == CFG_10 && link_a_extra_lane_keepalive
		&& !off_a |=> lane_data[7] == {8{$past(ramp)}})
		else $error("keepalive lane not toggling");
	test_guard_a: assert property (do_write && wr_addr == TEST_OFS && link_enable
		|=> $stable(test_pattern_select))
		else $error("test select changed while link enabled");

	bind_c: cover property (take && bind_a);
	pin_c: cover property (pd_state ##1 !pd_state);
	cfg12_c: cover property (take && link_configuration_select == CFG_12);
	ramp_c: cover property (take && test_pattern_select == TEST_RAMP);
	keep_c: cover property (take && link_a_extra_lane_keepalive);
endmodule : lane_mapping_power_control
`default_nettype wire

// File: lane_receiver_model.sv
// receiver-side model: captures lane frames while its link is up
// assumes the mapper's lane outputs and one shared clock
`timescale 1ns/100ps
`default_nettype none
module lane_receiver_model
	import lane_map_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// lanes from mapper
	input wire logic [lane_map_pkg::FRAME_W-1:0] lane_data [lane_map_pkg::LANES],
	input wire logic [lane_map_pkg::LANES-1:0] lane_enable,
	input wire logic frame_strobe,
	// link control and capture
	input wire logic relink,
	output var logic [lane_map_pkg::FRAME_W-1:0] rx_lane [lane_map_pkg::LANES],
	output var logic [15:0] rx_frames
);
	logic link_up;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn || lane_enable == '0) begin
			link_up <= 1'b0;
		end else if (relink) begin
			link_up <= 1'b1;
		end
		if (!aresetn) begin
			rx_frames <= '0;
		end else if (link_up && frame_strobe) begin
			rx_lane <= lane_data;
			rx_frames <= rx_frames + 16'h1;
		end
	end
endmodule : lane_receiver_model
`default_nettype wire

// File: lane_mapping_power_control_test.sv
// testbench: register accesses, frames and power control of the lane mapper
// assumes the receiver model beside the mapper and a 20 MHz clock
`timescale 1ns/100ps
`default_nettype none
module lane_mapping_power_control_test;
	import lane_map_pkg::*;
	localparam logic [31:0] LE = 32'h1 << LINK_EN_BIT;
	localparam logic [31:0] BA = 32'h1 << BIND_A_BIT;
	localparam logic [31:0] PA = 32'h1 << PD_A_BIT;
	localparam logic [31:0] PB = 32'h1 << PD_B_BIT;
	localparam logic [31:0] XA = 32'h1 << EXTRA_A_BIT;
	localparam logic [31:0] XB = 32'h1 << EXTRA_B_BIT;
	logic aclk = 1'b0, aresetn = 1'b0, power_down_pin = 1'b0, frame_valid = 1'b0, relink = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hf;
	logic [SAMPLE_VEC_W-1:0] chan_a_inphase, chan_a_quadrature, chan_b_inphase, chan_b_quadrature;
	logic awready, wready, bvalid, arready, rvalid, frame_strobe;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [FRAME_W-1:0] lane_data [LANES];
	logic [FRAME_W-1:0] rx_lane [LANES];
	logic [LANES-1:0] lane_enable;
	logic [15:0] rx_frames;
	logic [15:0] en_tab [9] = '{16'h0303, 16'h0f0f, 16'hffff, 16'h0101, 16'h0303, 16'h0001, 16'h0101, 16'hffff, 16'hffff};
	int mismatches = 0;
	int total_checks = 0;
	always #25 aclk = ~aclk;
	lane_mapping_power_control uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.power_down_pin, .frame_valid, .chan_a_inphase, .chan_a_quadrature, .chan_b_inphase,
		.chan_b_quadrature, .lane_data, .lane_enable, .frame_strobe);
	lane_receiver_model rx_model (.aclk, .aresetn, .lane_data, .lane_enable, .frame_strobe, .relink,
		.rx_lane, .rx_frames);
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] smp(input int ch, input int n);
		return 16'(16'h1110 * (ch + 1) + n);
	endfunction : smp
	function automatic logic [15:0] s15(input int ch, input int n);
		logic [15:0] v;
		v = smp(ch, n);
		return {v[14:0], 1'b0};
	endfunction : s15
	function automatic logic [63:0] e12(input int ch, input int p);
		logic [63:0] v;
		logic [15:0] s;
		v = '0;
		for (int j = 0; j < 5; j++) begin
			s = smp(ch, p + 4 * j);
			v[63 - 12 * j -: 12] = s[11:0];
		end
		return v;
	endfunction : e12
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test
	task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : check
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : settle
	task automatic timed_out(input int n);
		if (n >= 40) begin
			$display("BAD bus wait expected answer seen none");
			mismatches++;
			stop_test();
		end
	endtask : timed_out
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 40);
		bready <= 1'b0;
		timed_out(n);
		check("bresp", 64'(er), 64'(bresp));
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 40);
		rready <= 1'b0;
		timed_out(n);
		check("rresp", 64'(er), 64'(rresp));
		check("rdata", 64'(ed), 64'(rdata));
	endtask : axi_read
	task automatic en_chk(input logic [31:0] ctrl, input logic [15:0] e);
		axi_write(CTRL_OFS, ctrl, RESP_OKAY);
		settle(2);
		check("lane_enable", 64'(e), 64'(lane_enable));
	endtask : en_chk
	task automatic frame(input logic [31:0] ctrl);
		axi_write(CTRL_OFS, ctrl, RESP_OKAY);
		@(posedge aclk);
		frame_valid <= 1'b1;
		@(posedge aclk);
		frame_valid <= 1'b0;
		#1;
		check("frame_strobe", 64'h1, 64'(frame_strobe));
		settle(1);
	endtask : frame
	task automatic do_relink();
		@(posedge aclk);
		relink <= 1'b1;
		@(posedge aclk);
		relink <= 1'b0;
	endtask : do_relink
	////////////////////////////////////////////////////////////////
	initial begin
		for (int n = 0; n < SAMPLES; n++) begin
			chan_a_inphase[16 * n +: 16] = smp(0, n);
			chan_a_quadrature[16 * n +: 16] = smp(1, n);
			chan_b_inphase[16 * n +: 16] = smp(2, n);
			chan_b_quadrature[16 * n +: 16] = smp(3, n);
		end
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		settle(2);
		check("lane_enable", 64'h0303, 64'(lane_enable));
		axi_read(CTRL_OFS, RESP_OKAY, CTRL_RESET);
		axi_read(POWER_STATE_OFS, RESP_OKAY, 32'(POWER_STATE_RESET));
		axi_read(8'h10, RESP_SLVERR, 32'h0);
		axi_write(8'h10, 32'hffff_ffff, RESP_SLVERR);
		axi_write(TEST_OFS, 32'(TEST_TOGGLE), RESP_OKAY);
		axi_read(TEST_OFS, RESP_OKAY, 32'(TEST_TOGGLE));
		for (int i = 0; i < 9; i++) en_chk(32'(10 + i), en_tab[i]);
		axi_write(TEST_OFS, 32'(TEST_OFF), RESP_OKAY);
		do_relink();
		frame(LE | 32'(CFG_10));
		check("cfg10 ai", {s15(0, 0), 48'h0}, rx_lane[0]);
		check("cfg10 bq", {s15(3, 0), 48'h0}, rx_lane[9]);
		axi_write(TEST_OFS, 32'(TEST_RAMP), RESP_OKAY);
		axi_read(TEST_OFS, RESP_OKAY, 32'(TEST_OFF));
		frame(LE | 32'(CFG_15));
		check("cfg15", {s15(0, 0), s15(1, 0), s15(2, 0), s15(3, 0)}, rx_lane[0]);
		frame(LE | 32'(CFG_18));
		for (int k = 0; k < 8; k++) begin
			check("cfg18 a", {smp(0, k) & 16'h00ff, 48'h0} << 8, rx_lane[k]);
			check("cfg18 b", {smp(2, k) & 16'h00ff, 48'h0} << 8, rx_lane[8 + k]);
		end
		frame(LE | 32'(CFG_12));
		for (int k = 0; k < 16; k++) check("cfg12", e12(2 * (k / 8) + k % 2, (k % 8) / 2), rx_lane[k]);
		frame(LE | 32'(CFG_17));
		for (int k = 0; k < 8; k++) begin
			check("cfg17 a", {smp(0, 2 * k) & 16'h00ff, 48'h0} << 8, rx_lane[k]);
			check("cfg17 b", {smp(0, 2 * k + 1) & 16'h00ff, 48'h0} << 8, rx_lane[8 + k]);
		end
		frame(LE | BA | 32'(CFG_18));
		for (int k = 0; k < 8; k++) begin
			check("bound18", {smp(0, k) & 16'h00ff, 48'h0} << 8, rx_lane[8 + k]);
		end
		frame(LE | 32'(CFG_11));
		for (int k = 0; k < 4; k++) begin
			check("cfg11 a", {s15(k / 2, k % 2), 48'h0}, rx_lane[k]);
			check("cfg11 b", {s15(2 + k / 2, k % 2), 48'h0}, rx_lane[8 + k]);
		end
		for (int c = 0; c < 2; c++) begin
			frame(LE | 32'(c == 0 ? CFG_13 : CFG_16));
			check("cfg13 16 a", {s15(0, 0), s15(1, 0), 32'h0}, rx_lane[0]);
			check("cfg13 16 b", {s15(2, 0), s15(3, 0), 32'h0}, rx_lane[8]);
		end
		frame(LE | 32'(CFG_14));
		check("cfg14 aq", {s15(1, 0), 48'h0}, rx_lane[1]);
		frame(LE | BA | 32'(CFG_10));
		check("bound bi", {s15(0, 0), 48'h0}, rx_lane[8]);
		check("bound bq", {s15(1, 0), 48'h0}, rx_lane[9]);
		en_chk(LE | BA | PB | 32'(CFG_10), 16'h0303);
		en_chk(LE | PA | 32'(CFG_10), 16'h0300);
		en_chk(XA | 32'(CFG_10), 16'h03ff);
		en_chk(XB | 32'(CFG_13), 16'hff01);
		axi_write(POWER_STATE_OFS, 32'h2, RESP_OKAY);
		settle(2);
		check("lane_enable", 64'h0, 64'(lane_enable));
		axi_read(STATUS_OFS, RESP_OKAY, 32'h1 << STATUS_ALL_OFF_BIT);
		axi_write(POWER_STATE_OFS, 32'(POWER_STATE_MAX_ON), RESP_OKAY);
		en_chk(LE | 32'(CFG_10), 16'h0303);
		@(posedge aclk);
		power_down_pin <= 1'b1;
		settle(8);
		check("lane_enable", 64'h0, 64'(lane_enable));
		@(posedge aclk);
		power_down_pin <= 1'b0;
		settle(8);
		check("lane_enable", 64'h0303, 64'(lane_enable));
		do_relink();
		frame(LE | 32'(CFG_10));
		check("rx_frames", 64'h0c, 64'(rx_frames));
		axi_write(CTRL_OFS, 32'(CFG_10), RESP_OKAY);
		axi_write(TEST_OFS, 32'(TEST_RAMP), RESP_OKAY);
		frame(LE | XA | 32'(CFG_10));
		check("ramp", {8{8'h0c}}, rx_lane[0]);
		check("keepalive", {8{8'h0c}}, rx_lane[7]);
		axi_write(CTRL_OFS, 32'(CFG_10), RESP_OKAY);
		axi_write(TEST_OFS, 32'(TEST_TOGGLE), RESP_OKAY);
		frame(LE | 32'(CFG_10));
		check("toggle", 64'hffff_ffff_ffff_ffff, rx_lane[1]);
		stop_test();
	end
endmodule : lane_mapping_power_control_test
`default_nettype wire
